// >>> hdl/tbos_map.svh
// Register offsets, field positions and reset values of the burst sequencer
`ifndef TBOS_MAP_SVH
`define TBOS_MAP_SVH
// ==========================================================
// Offsets
`define TBOS_OFS_BOARD_CTRL 8'h00
`define TBOS_OFS_BUF_OPS 8'h04
`define TBOS_OFS_RATE 8'h08
`define TBOS_OFS_BUF_DATA 8'h18
// ==========================================================
// Board control fields
`define TBOS_BC_SIMUL 0
`define TBOS_BC_BURST_EN 1
`define TBOS_BC_SW_TRIG 2
// ==========================================================
// Buffer operations fields
`define TBOS_BO_FLUSH 0
`define TBOS_BO_CIRC 1
`define TBOS_BO_EXT_CLK 2
`define TBOS_BO_CLK_EN 3
`define TBOS_BO_EMPTY 8
`define TBOS_BO_BUSY 9
// ==========================================================
// Buffer word and reset values
`define TBOS_EOF_BIT 16
`define TBOS_RATE_RST 32'h0000_00ff
`endif

// >>> hdl/tbos_pkg.sv
// Types shared by the burst sequencer
`default_nettype none
package tbos_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_send = 2'b10
  } tbos_state_e;
endpackage
`default_nettype wire

// >>> hdl/tbos_fifo.sv
// Small show-ahead FIFO between the host write port and the burst buffer
`timescale 1ns/100ps
`default_nettype none
module tbos_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic rdy;
  } tbos_fifo_state_s;
  tbos_fifo_state_s s_reg, s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign push = in_valid_in && s_reg.rdy;
  assign pop = out_valid_out && out_ready_in;
  assign in_ready_out = s_reg.rdy;
  assign out_valid_out = (s_reg.cnt != '0);
  assign out_data_out = mem[s_reg.rd];

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wr = ptr_inc(s_reg.wr);
    end
    if (pop) begin
      s_next.rd = ptr_inc(s_reg.rd);
    end
    s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
    if (flush_in) begin
      s_next.wr = '0;
      s_next.rd = '0;
      s_next.cnt = '0;
    end
    // Registered so the host sees ready straight from a flop
    s_next.rdy = (s_next.cnt != CW'(DEPTH));
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_reg <= '{wr: '0, rd: '0, cnt: '0, rdy: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[s_reg.wr] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/tbos_top.sv
// Triggered-burst output sequencer: registers, burst buffer, clocking and burst control
`timescale 1ns/100ps
`default_nettype none
`include "tbos_map.svh"
module tbos_top #(
  parameter int DEPTH = 256,
  parameter int GROUP = 4,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic buf_ready_out,
  // External clock and trigger
  input wire logic ext_clk_in,
  input wire logic ext_trig_in,
  // Converter side
  output logic [15:0] dac_data_out,
  output logic [$clog2(GROUP)-1:0] dac_chan_out,
  output logic dac_load_out,
  output logic dac_update_out,
  output logic burst_ready_irq_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int GW = $clog2(GROUP);
  localparam int WW = `TBOS_EOF_BIT + 1;

  typedef struct packed {
    tbos_pkg::tbos_state_e st;
    logic simul;
    logic burst_en;
    logic sw_trig;
    logic circ;
    logic ext_clk;
    logic clk_en;
    logic [31:0] rate;
    logic [31:0] div;
    logic ext_q;
    logic trig_q;
    logic tick;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic [GW-1:0] grp;
    logic [15:0] dac_data;
    logic [GW-1:0] dac_chan;
    logic dac_load;
    logic dac_update;
    logic irq;
    logic [31:0] rdata;
    logic rvalid;
  } tbos_top_state_s;

  tbos_top_state_s s_reg, s_next;
  logic [WW-1:0] mem [DEPTH];
  logic [WW-1:0] head;
  logic wr_ctrl, wr_ops, wr_rate, wr_data, flush;
  logic fifo_ready, fifo_valid, drain_ready, drain;
  logic [WW-1:0] fifo_data;
  logic trig_fall, ext_rise, consume, last;

  // ==========================================================
  // Register decode
  function automatic logic hit(input logic [7:0] ofs);
    hit = reg_wr_in && (reg_addr_in == ofs);
  endfunction

  assign wr_ctrl = hit(`TBOS_OFS_BOARD_CTRL);
  assign wr_ops = hit(`TBOS_OFS_BUF_OPS);
  assign wr_rate = hit(`TBOS_OFS_RATE);
  assign wr_data = hit(`TBOS_OFS_BUF_DATA);
  // flush is a command, not stored
  assign flush = wr_ops && reg_wdata_in[`TBOS_BO_FLUSH];

  // ==========================================================
  // Host data FIFO
  // Closed circular buffer refuses new words, so the FIFO backs up to the host
  assign drain_ready = (s_reg.cnt != CW'(DEPTH)) && !s_reg.circ && !flush;
  assign drain = fifo_valid && drain_ready;

  tbos_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .flush_in(flush),
    .in_valid_in(wr_data),
    .in_data_in(reg_wdata_in[WW-1:0]),
    .in_ready_out(fifo_ready),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(drain_ready)
  );

  // marker bit stored with its entry
  always_ff @(posedge core_clk_in) begin
    if (drain) begin
      mem[s_reg.wr] <= fifo_data;
    end
  end

  assign head = mem[s_reg.rd];
  assign trig_fall = s_reg.trig_q && !ext_trig_in;
  assign ext_rise = ext_clk_in && !s_reg.ext_q;
  assign consume = (s_reg.st == tbos_pkg::st_send) && s_reg.clk_en && (s_reg.cnt != '0);
  assign last = head[`TBOS_EOF_BIT] || (s_reg.grp == GW'(GROUP - 1));

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.ext_q = ext_clk_in;
    s_next.trig_q = ext_trig_in;
    s_next.tick = 1'b0;
    s_next.dac_load = 1'b0;
    s_next.dac_update = 1'b0;
    s_next.irq = 1'b0;
    s_next.rvalid = reg_rd_in;
    s_next.rdata = '0;

    // Sample clock source
    if (!s_reg.clk_en) begin
      s_next.div = '0;
    end else if (s_reg.ext_clk) begin
      s_next.tick = ext_rise;
    end else if (s_reg.div >= s_reg.rate) begin
      s_next.div = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.div = s_reg.div + 32'h0000_0001;
    end

    if (drain) begin
      s_next.wr = s_reg.wr + AW'(1);
    end

    case (s_reg.st)
      tbos_pkg::st_idle: begin
        // burst mode waits for a trigger
        if (s_reg.clk_en && (!s_reg.burst_en || s_reg.sw_trig || trig_fall)) begin
          s_next.st = tbos_pkg::st_wait;
        end
      end
      tbos_pkg::st_wait: begin
        if (s_reg.tick) begin
          s_next.st = tbos_pkg::st_send;
          s_next.grp = '0;
        end
      end
      tbos_pkg::st_send: begin
        // Empty open buffer stalls the group until data arrives
        if (consume) begin
          s_next.dac_data = head[15:0];
          s_next.dac_chan = s_reg.grp;
          s_next.dac_load = 1'b1;
          // simultaneous mode: one update for the whole group; otherwise one per word
          s_next.dac_update = !s_reg.simul || last;
          // circular wraps back to oldest entry
          if (s_reg.circ) begin
            s_next.rd = (s_reg.rd + AW'(1) == s_reg.wr) ? s_reg.wr - s_reg.cnt[AW-1:0] : s_reg.rd + AW'(1);
          // open buffer consumes words in order
          end else begin
            s_next.rd = s_reg.rd + AW'(1);
          end
          s_next.grp = s_reg.grp + GW'(1);
          if (last) begin
            s_next.st = tbos_pkg::st_wait;
          end
          // burst ends on the marked entry
          if (head[`TBOS_EOF_BIT] && s_reg.burst_en) begin
            s_next.st = tbos_pkg::st_idle;
            s_next.sw_trig = 1'b0;
            s_next.irq = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = tbos_pkg::st_idle;
      end
    endcase

    s_next.cnt = s_reg.cnt + CW'(drain) - CW'(consume && !s_reg.circ);

    // clock run low stops all output
    if (!s_reg.clk_en) begin
      s_next.st = tbos_pkg::st_idle;
    end

    // Register writes come last so a host set wins over the self-clear
    if (wr_ctrl) begin
      s_next.simul = reg_wdata_in[`TBOS_BC_SIMUL];
      s_next.burst_en = reg_wdata_in[`TBOS_BC_BURST_EN];
      s_next.sw_trig = reg_wdata_in[`TBOS_BC_SW_TRIG];
    end
    // all mode bits taken in one write
    if (wr_ops) begin
      s_next.circ = reg_wdata_in[`TBOS_BO_CIRC];
      s_next.ext_clk = reg_wdata_in[`TBOS_BO_EXT_CLK];
      s_next.clk_en = reg_wdata_in[`TBOS_BO_CLK_EN];
    end
    if (wr_rate) begin
      s_next.rate = reg_wdata_in;
    end
    // flush empties buffer and aborts any burst
    if (flush) begin
      s_next.wr = '0;
      s_next.rd = '0;
      s_next.cnt = '0;
      s_next.st = tbos_pkg::st_idle;
    end

    // Read-back
    case (reg_addr_in)
      `TBOS_OFS_BOARD_CTRL: begin
        s_next.rdata[`TBOS_BC_SIMUL] = s_reg.simul;
        s_next.rdata[`TBOS_BC_BURST_EN] = s_reg.burst_en;
        s_next.rdata[`TBOS_BC_SW_TRIG] = s_reg.sw_trig;
      end
      `TBOS_OFS_BUF_OPS: begin
        s_next.rdata[`TBOS_BO_CIRC] = s_reg.circ;
        s_next.rdata[`TBOS_BO_EXT_CLK] = s_reg.ext_clk;
        s_next.rdata[`TBOS_BO_CLK_EN] = s_reg.clk_en;
        s_next.rdata[`TBOS_BO_EMPTY] = (s_reg.cnt == '0);
        s_next.rdata[`TBOS_BO_BUSY] = (s_reg.st != tbos_pkg::st_idle);
      end
      `TBOS_OFS_RATE: begin
        s_next.rdata = s_reg.rate;
      end
      default: begin
        s_next.rdata = '0;
      end
    endcase
    if (!reg_rd_in) begin
      s_next.rdata = s_reg.rdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.rate <= `TBOS_RATE_RST;
      s_reg.trig_q <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // FIFO ready registered again and ANDed with the FIFO ready, so the port rises a cycle late but falls at once
  logic ready_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= fifo_ready;
    end
  end

  assign buf_ready_out = ready_q && fifo_ready;
  assign reg_rdata_out = s_reg.rdata;
  assign reg_rvalid_out = s_reg.rvalid;
  assign dac_data_out = s_reg.dac_data;
  assign dac_chan_out = s_reg.dac_chan;
  assign dac_load_out = s_reg.dac_load;
  assign dac_update_out = s_reg.dac_update;
  assign burst_ready_irq_out = s_reg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence seq_flush_write;
    wr_ops && reg_wdata_in[`TBOS_BO_FLUSH];
  endsequence
  sequence seq_tick_in_wait;
    s_reg.st == tbos_pkg::st_wait && s_reg.tick && s_reg.clk_en && !flush;
  endsequence

  AST_FLUSH_EMPTIES: assert property (seq_flush_write |=> s_reg.cnt == '0 && s_reg.st == tbos_pkg::st_idle)
    else $error("flush did not empty buffer");
  AST_CLK_STOP: assert property (!s_reg.clk_en && !wr_ops |=> !s_reg.dac_load && s_reg.st == tbos_pkg::st_idle)
    else $error("output continued with clock stopped");
  AST_SIMUL_UPDATE: assert property (s_reg.dac_update |-> s_reg.dac_load)
    else $error("update without load");
  AST_SIMUL_HOLD: assert property (consume && s_reg.simul && !last |=> !s_reg.dac_update)
    else $error("simultaneous group updated early");
  AST_EOF_STORED: assert property (drain && fifo_data[`TBOS_EOF_BIT] |=> mem[$past(s_reg.wr)][`TBOS_EOF_BIT])
    else $error("frame end marker lost");
  AST_RATE_WRITE: assert property (wr_rate |=> s_reg.rate == $past(reg_wdata_in))
    else $error("rate register not updated");
  AST_CIRC_KEEPS: assert property (consume && s_reg.circ && !drain && !flush |=> $stable(s_reg.cnt))
    else $error("circular buffer consumed data");
  AST_IDLE_HOLD: assert property (s_reg.st == tbos_pkg::st_idle && s_reg.burst_en && !s_reg.sw_trig && !trig_fall
    |=> s_reg.st == tbos_pkg::st_idle ##1 !s_reg.dac_load)
    else $error("burst started without trigger");
  AST_TRIG_CLEAR: assert property (s_reg.irq && !$past(wr_ctrl) |-> !s_reg.sw_trig)
    else $error("software trigger not cleared");
  AST_IRQ_ON_END: assert property (s_reg.irq |-> s_reg.dac_load && s_reg.dac_update && s_reg.st == tbos_pkg::st_idle)
    else $error("burst ready without final update");
  AST_EXT_TRIG: assert property (s_reg.st == tbos_pkg::st_idle && s_reg.clk_en && s_reg.burst_en && trig_fall
    && !wr_ops |=> s_reg.st == tbos_pkg::st_wait)
    else $error("external trigger edge missed");
  AST_TICK_SENDS: assert property (seq_tick_in_wait |=> s_reg.st == tbos_pkg::st_send)
    else $error("sample tick did not start group");
endmodule
`default_nettype wire

// >>> verif/tbos_ext_src.sv
// Model of the external sample clock and burst trigger source
`timescale 1ns/100ps
`default_nettype none
module tbos_ext_src #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic core_clk_in,
  // Commands from the bench
  input wire logic run_in,
  input wire logic trig_req_in,
  // Board connector
  output logic ext_clk_out,
  output logic ext_trig_out
);
  int cnt = 0;
  int low = 0;
  logic req;
  initial begin
    ext_clk_out = 1'b0;
    ext_trig_out = 1'b1;
  end
  // Clock stands low while stopped
  always @(posedge core_clk_in) begin
    req = trig_req_in;
    #1;
    if (run_in) begin
      if (cnt == HALF - 1) begin
        cnt = 0;
        ext_clk_out = ~ext_clk_out;
      end else begin
        cnt++;
      end
    end else begin
      cnt = 0;
      ext_clk_out = 1'b0;
    end
    if (req) begin
      low = 4;
    end
    ext_trig_out = (low == 0);
    if (low > 0) begin
      low--;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_triggered_burst_output_sequencer.sv
// Self-checking bench of the triggered-burst sequencer
`timescale 1ns/100ps
`default_nettype none
`include "tbos_map.svh"
module tb_triggered_burst_output_sequencer;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic [31:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic buf_ready_out;
  logic ext_clk;
  logic ext_trig;
  logic ext_run = 1'b0;
  logic trig_req = 1'b0;
  logic [15:0] dac_data_out;
  logic [1:0] dac_chan_out;
  logic dac_load_out;
  logic dac_update_out;
  logic burst_ready_irq_out;
  int num_errors = 0;
  int n_tests = 0;
  int n_load = 0;
  int n_upd = 0;
  int n_irq = 0;
  int k;
  logic [31:0] rv;
  logic [15:0] seen_q[$];
  logic [15:0] exp_q[$];
  logic [1:0] chan_q[$];

  tbos_top #(.DEPTH(16), .GROUP(4), .FIFO_DEPTH(4)) dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .buf_ready_out(buf_ready_out),
    .ext_clk_in(ext_clk), .ext_trig_in(ext_trig), .dac_data_out(dac_data_out),
    .dac_chan_out(dac_chan_out), .dac_load_out(dac_load_out), .dac_update_out(dac_update_out),
    .burst_ready_irq_out(burst_ready_irq_out));

  tbos_ext_src src (.core_clk_in(core_clk_in), .run_in(ext_run), .trig_req_in(trig_req),
    .ext_clk_out(ext_clk), .ext_trig_out(ext_trig));

  always #2 core_clk_in = ~core_clk_in;

  // =========================================================
  // Converter side monitor
  always @(posedge core_clk_in) begin
    if (!rst_in) begin
      if (dac_load_out === 1'b1) begin
        n_load++;
        seen_q.push_back(dac_data_out);
        chan_q.push_back(dac_chan_out);
      end
      if (dac_update_out === 1'b1) n_upd++;
      if (burst_ready_irq_out === 1'b1) n_irq++;
    end
  end

  // =========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    #1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    #1;
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    reg_rd_in = 1'b0;
    chk({31'h0000_0000, reg_rvalid_out}, 32'h0000_0001, "read valid");
    d = reg_rdata_out;
  endtask

  // Waits for room in the write FIFO, then stores one word with its marker
  task automatic put(input logic [15:0] v, input logic eof);
    int n;
    n = 0;
    while (buf_ready_out !== 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    wr(`TBOS_OFS_BUF_DATA, {15'h0000, eof, v});
  endtask

  task automatic clr();
    n_load = 0;
    n_upd = 0;
    n_irq = 0;
    seen_q.delete();
    chan_q.delete();
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (n_irq < 1 && n < 400) begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (2) @(posedge core_clk_in);
  endtask

  task automatic chk_seq();
    chk(n_load, exp_q.size(), "words in burst");
    foreach (exp_q[i]) begin
      if (i < seen_q.size()) chk(seen_q[i], exp_q[i], "burst word");
      if (i < chan_q.size()) chk(chan_q[i], i, "channel index");
    end
    chk(n_irq, 1, "burst ready pulses");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 4);
    num_errors++;
    give_verdict();
  end

  // =========================================================
  // Tests
  initial begin
    repeat (4) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    rd(`TBOS_OFS_RATE, rv); chk(rv, `TBOS_RATE_RST, "rate reset");
    rd(`TBOS_OFS_BOARD_CTRL, rv); chk(rv, 32'h0000_0000, "board reset");
    rd(`TBOS_OFS_BUF_OPS, rv); chk(rv, 32'h0000_0100, "ops reset");
    rd(8'h40, rv); chk(rv, 32'h0000_0000, "unmapped read");
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_0001);
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0001);
    for (k = 0; k < 4; k++) put(16'h1000 + 16'(k), k == 3);
    for (k = 0; k < 2; k++) put(16'h2000 + 16'(k), k == 1);
    wr(`TBOS_OFS_RATE, 32'h0000_0003);
    rd(`TBOS_OFS_RATE, rv); chk(rv, 32'h0000_0003, "rate readback");
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0003);
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_0008);
    clr();
    repeat (40) @(posedge core_clk_in);
    chk(n_load, 0, "idle before trigger");
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0007);
    wait_irq();
    exp_q = '{16'h1000, 16'h1001, 16'h1002, 16'h1003};
    chk_seq();
    chk(n_upd, 1, "simultaneous updates");
    repeat (20) @(posedge core_clk_in);
    chk(n_load, 4, "stop at marker");
    rd(`TBOS_OFS_BOARD_CTRL, rv); chk(rv, 32'h0000_0003, "trigger self clear");
    // External falling edge releases the second function
    clr();
    @(posedge core_clk_in);
    #1;
    trig_req = 1'b1;
    @(posedge core_clk_in);
    #1;
    trig_req = 1'b0;
    wait_irq();
    exp_q = '{16'h2000, 16'h2001};
    chk_seq();
    // Circular, external clock and run in one write
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_0001);
    rd(`TBOS_OFS_BUF_OPS, rv); chk(rv & 32'h0000_0100, 32'h0000_0100, "flush empties");
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0002);
    put(16'h3000, 1'b0);
    put(16'h3001, 1'b1);
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_000e);
    rd(`TBOS_OFS_BUF_OPS, rv); chk(rv, 32'h0000_000e, "ops one write");
    clr();
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0006);
    repeat (30) @(posedge core_clk_in);
    chk(n_load, 0, "no tick without external clock");
    rd(`TBOS_OFS_BUF_OPS, rv); chk(rv, 32'h0000_020e, "busy waiting for tick");
    ext_run = 1'b1;
    wait_irq();
    exp_q = '{16'h3000, 16'h3001};
    chk_seq();
    chk(n_upd, 2, "update per word");
    clr();
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0006);
    wait_irq();
    chk_seq();
    // Clock run off blocks output
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_0006);
    clr();
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0006);
    repeat (40) @(posedge core_clk_in);
    chk(n_load, 0, "clock stopped");
    // Burst select off: output runs on past the marker, no ready pulse
    wr(`TBOS_OFS_BOARD_CTRL, 32'h0000_0000);
    clr();
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_000a);
    repeat (40) @(posedge core_clk_in);
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_0002);
    for (k = 0; k < 4; k++) chk(seen_q[k], 16'h3000 + 16'(k % 2), "continuous word");
    chk(n_irq, 0, "no ready without burst mode");
    // Closed buffer holds the drain, so the FIFO fills
    k = 0;
    while (buf_ready_out === 1'b1 && k < 8) begin
      wr(`TBOS_OFS_BUF_DATA, 32'h0000_4000 + k);
      k++;
      repeat (2) @(posedge core_clk_in);
    end
    chk(k, 4, "fifo depth");
    wr(`TBOS_OFS_BUF_OPS, 32'h0000_0001);
    repeat (4) @(posedge core_clk_in);
    chk({31'h0000_0000, buf_ready_out}, 32'h0000_0001, "ready after flush");
    rd(`TBOS_OFS_BUF_OPS, rv); chk(rv & 32'h0000_0100, 32'h0000_0100, "empty after flush");
    give_verdict();
  end
endmodule
`default_nettype wire
